// >>> ibf_regs.svh
// Purpose: constants for the instruction buffer fetch and issue front end
// Assumes: 24-bit parcel address, 64-bit memory words of four parcels
// Notes: definitions only
`ifndef IBF_REGS_SVH
`define IBF_REGS_SVH
`define IBF_NUM_BUF 4
`define IBF_BUF_PARCELS 64
`define IBF_PARCEL_W 16
`define IBF_PADDR_W 24
`define IBF_TAG_W 18
`define IBF_WADDR_W 22
`define IBF_WORD_W 64
`define IBF_REFILL_WORDS 16
`define IBF_AJ_ZERO 24'h000000
`define IBF_AK_ZERO 24'h000001
`define IBF_SJ_ZERO 64'h0000000000000000
`define IBF_SK_ZERO 64'h8000000000000000
`endif

// >>> ibf_pkg.sv
// Purpose: types for the instruction buffer front end
// Assumes: ibf_regs.svh holds the numbers
// Notes: refill word request and return carried as structs
`include "ibf_regs.svh"
package ibf_pkg;
  typedef enum logic [1:0] {
    IBF_RUN = 2'b00,
    IBF_FILL = 2'b01,
    IBF_WAIT = 2'b11
  } ibf_state_t;
  typedef struct packed {
    logic valid;
    logic [`IBF_WADDR_W-1:0] addr;
  } ibf_mreq_t;
  typedef struct packed {
    logic valid;
    logic [`IBF_WORD_W-1:0] data;
  } ibf_mrsp_t;
  typedef struct packed {
    logic valid;
    logic two_parcel;
    logic [`IBF_PARCEL_W-1:0] first;
    logic [`IBF_PARCEL_W-1:0] second;
    logic [`IBF_PADDR_W-1:0] addr;
  } ibf_issue_t;
endpackage : ibf_pkg

// >>> ibf_zero_sub.sv
// Purpose: zero-register operand substitution
// Assumes: operands sampled on clk alongside the issued instruction
// Notes: registered so outputs come from flip-flops
`timescale 1ns/1ps
`include "ibf_regs.svh"
module ibf_zero_sub
  import ibf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] i_sel,
  input wire logic [2:0] j_sel,
  input wire logic [2:0] k_sel,
  input wire logic [`IBF_PADDR_W-1:0] ai_val,
  input wire logic [`IBF_PADDR_W-1:0] aj_val,
  input wire logic [`IBF_PADDR_W-1:0] ak_val,
  input wire logic [`IBF_WORD_W-1:0] si_val,
  input wire logic [`IBF_WORD_W-1:0] sj_val,
  input wire logic [`IBF_WORD_W-1:0] sk_val,
  output logic [`IBF_PADDR_W-1:0] ai_op,
  output logic [`IBF_PADDR_W-1:0] aj_op,
  output logic [`IBF_PADDR_W-1:0] ak_op,
  output logic [`IBF_WORD_W-1:0] si_op,
  output logic [`IBF_WORD_W-1:0] sj_op,
  output logic [`IBF_WORD_W-1:0] sk_op
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ai_op <= '0;
      aj_op <= '0;
      ak_op <= '0;
      si_op <= '0;
      sj_op <= '0;
      sk_op <= '0;
    end else begin
      // the i operand is never substituted, so i_sel has no say here
      ai_op <= ai_val;
      si_op <= si_val;
      aj_op <= (j_sel == 3'h0) ? `IBF_AJ_ZERO : aj_val;
      ak_op <= (k_sel == 3'h0) ? `IBF_AK_ZERO : ak_val;
      sj_op <= (j_sel == 3'h0) ? `IBF_SJ_ZERO : sj_val;
      sk_op <= (k_sel == 3'h0) ? `IBF_SK_ZERO : sk_val;
    end
  end
endmodule : ibf_zero_sub

// >>> ibf_fetch.sv
// Purpose: instruction buffer fetch and issue front end
// Assumes: memory returns refill words in request order, one per cycle at most
// Notes: refill starts at the bank 0 word of the 16-word group holding p
`timescale 1ns/1ps
`include "ibf_regs.svh"
module ibf_fetch
  import ibf_pkg::*;
#(
  parameter int NUM_BUF = `IBF_NUM_BUF,
  parameter int BUF_PARCELS = `IBF_BUF_PARCELS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic branch,
  input wire logic [`IBF_PADDR_W-1:0] branch_addr,
  input wire logic issue_ready,
  input wire logic two_parcel_op,
  input wire ibf_mrsp_t mem_rsp,
  input wire logic [2:0] i_sel,
  input wire logic [2:0] j_sel,
  input wire logic [2:0] k_sel,
  input wire logic [`IBF_PADDR_W-1:0] ai_val,
  input wire logic [`IBF_PADDR_W-1:0] aj_val,
  input wire logic [`IBF_PADDR_W-1:0] ak_val,
  input wire logic [`IBF_WORD_W-1:0] si_val,
  input wire logic [`IBF_WORD_W-1:0] sj_val,
  input wire logic [`IBF_WORD_W-1:0] sk_val,
  output ibf_mreq_t mem_req,
  output ibf_issue_t issue,
  output logic out_of_buffer,
  output logic [`IBF_PARCEL_W-1:0] next_parcel_reg,
  output logic [`IBF_PARCEL_W-1:0] current_parcel_reg,
  output logic [`IBF_PADDR_W-1:0] ai_op,
  output logic [`IBF_PADDR_W-1:0] aj_op,
  output logic [`IBF_PADDR_W-1:0] ak_op,
  output logic [`IBF_WORD_W-1:0] si_op,
  output logic [`IBF_WORD_W-1:0] sj_op,
  output logic [`IBF_WORD_W-1:0] sk_op
);
  localparam int WPB = BUF_PARCELS / 4;
  // 2-bit hit index and round-robin counter tie the logic to four buffers
  if (NUM_BUF != 4 || BUF_PARCELS != 64) begin : g_bad_param
    $error("ibf_fetch serves only four buffers of 64 parcels");
  end

  logic [`IBF_PARCEL_W-1:0] buf_q [NUM_BUF][BUF_PARCELS];
  logic [`IBF_TAG_W-1:0] tag_q [NUM_BUF];
  logic [NUM_BUF-1:0] tag_v_q;
  logic [WPB-1:0] wv_q [NUM_BUF];
  logic [`IBF_PADDR_W-1:0] p_q;
  logic [1:0] rr_q;
  ibf_state_t st_q;
  logic [3:0] req_cnt_q;
  logic [3:0] rsp_cnt_q;
  logic [`IBF_TAG_W-1:0] fill_tag_q;
  logic [NUM_BUF-1:0] hit;
  logic any_hit;
  logic [1:0] hit_idx;
  logic [`IBF_TAG_W-1:0] p_tag;
  logic [5:0] p_off;
  logic [5:0] p_off1;
  logic [`IBF_PARCEL_W-1:0] par0;
  logic [`IBF_PARCEL_W-1:0] par1;
  logic v0;
  logic v1;
  logic can_issue;

  assign p_tag = p_q[`IBF_PADDR_W-1:`IBF_PADDR_W-`IBF_TAG_W];
  assign p_off = p_q[5:0];
  assign p_off1 = p_off + 6'h01;

  // tag compare across every buffer each cycle
  always_comb begin
    hit_idx = 2'h0;
    for (int b = 0; b < NUM_BUF; b++) begin
      hit[b] = tag_v_q[b] && (tag_q[b] == p_tag);
      if (hit[b]) begin
        hit_idx = 2'(b);
      end
    end
  end
  assign any_hit = |hit;

  // a two-parcel at offset 63 spills past the buffer; its second is then never valid and issue stalls with no refill, as it does before its word arrives
  always_comb begin
    par0 = buf_q[hit_idx][p_off];
    par1 = buf_q[hit_idx][p_off1];
    v0 = any_hit && wv_q[hit_idx][p_off[5:2]];
    v1 = any_hit && (p_off != 6'h3f) && wv_q[hit_idx][p_off1[5:2]];
  end

  // a branch edge reloads p, so nothing may issue with stale fields then
  assign can_issue = (st_q == IBF_RUN) && !branch && v0 && (!two_parcel_op || v1) && issue_ready;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= IBF_RUN;
      rr_q <= 2'h0;
      req_cnt_q <= 4'h0;
      rsp_cnt_q <= 4'h0;
      fill_tag_q <= '0;
      out_of_buffer <= 1'b0;
    end else begin
      out_of_buffer <= 1'b0;
      case (st_q)
        IBF_RUN: begin
          if (!branch && !any_hit) begin
            out_of_buffer <= 1'b1;
            fill_tag_q <= p_tag;
            req_cnt_q <= 4'h0;
            rsp_cnt_q <= 4'h0;
            st_q <= IBF_FILL;
          end
        end
        IBF_FILL: begin
          if (req_cnt_q == 4'hf) begin
            st_q <= IBF_WAIT;
          end
          req_cnt_q <= req_cnt_q + 4'h1;
          if (mem_rsp.valid) begin
            rsp_cnt_q <= rsp_cnt_q + 4'h1;
          end
        end
        IBF_WAIT: begin
          if (mem_rsp.valid) begin
            rsp_cnt_q <= rsp_cnt_q + 4'h1;
            if (rsp_cnt_q == 4'hf) begin
              rr_q <= rr_q + 2'h1;
              st_q <= IBF_RUN;
            end
          end
        end
        default: st_q <= IBF_RUN;
      endcase
    end
  end

  // bank-interleaved request walk from the bank 0 word of the group
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_req <= '0;
    end else begin
      mem_req.valid <= (st_q == IBF_FILL);
      mem_req.addr <= {fill_tag_q, req_cnt_q};
    end
  end

  // refill write, tag and word-valid bookkeeping per buffer
  for (genvar b = 0; b < NUM_BUF; b++) begin : g_buf
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        tag_q[b] <= '0;
        tag_v_q[b] <= 1'b0;
        wv_q[b] <= '0;
      end else if (st_q == IBF_RUN && !branch && !any_hit && rr_q == 2'(b)) begin
        tag_q[b] <= p_tag;
        tag_v_q[b] <= 1'b1;
        wv_q[b] <= '0;
      end else if (st_q != IBF_RUN && rr_q == 2'(b) && mem_rsp.valid) begin
        wv_q[b][rsp_cnt_q] <= 1'b1;
      end
    end
    always_ff @(posedge clk) begin
      if (st_q != IBF_RUN && rr_q == 2'(b) && mem_rsp.valid) begin
        for (int q = 0; q < 4; q++) begin
          buf_q[b][{rsp_cnt_q, 2'(q)}] <= mem_rsp.data[63-16*q -: 16];
        end
      end
    end
  end

  // program address advance and parcel registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      p_q <= '0;
      next_parcel_reg <= '0;
      current_parcel_reg <= '0;
      issue <= '0;
    end else begin
      issue.valid <= can_issue;
      if (branch) begin
        p_q <= branch_addr;
      end else if (can_issue) begin
        current_parcel_reg <= par0;
        next_parcel_reg <= two_parcel_op ? par1 : next_parcel_reg;
        issue.first <= par0;
        issue.second <= two_parcel_op ? par1 : '0;
        issue.two_parcel <= two_parcel_op;
        issue.addr <= p_q;
        p_q <= p_q + (two_parcel_op ? 24'h000002 : 24'h000001);
      end else if (v0 && st_q == IBF_RUN) begin
        next_parcel_reg <= par0;
      end
    end
  end

  ibf_zero_sub u_zero (
    .clk(clk),
    .rst_b(rst_b),
    .i_sel(i_sel),
    .j_sel(j_sel),
    .k_sel(k_sel),
    .ai_val(ai_val),
    .aj_val(aj_val),
    .ak_val(ak_val),
    .si_val(si_val),
    .sj_val(sj_val),
    .sk_val(sk_val),
    .ai_op(ai_op),
    .aj_op(aj_op),
    .ak_op(ak_op),
    .si_op(si_op),
    .sj_op(sj_op),
    .sk_op(sk_op)
  );
endmodule : ibf_fetch

// >>> ibf_fetch_properties.sv
// Purpose: port checker for ibf_fetch
// Assumes: one clock, async active-low reset
// Notes: bound to every ibf_fetch
`timescale 1ns/1ps
`include "ibf_regs.svh"
module ibf_fetch_chk
  import ibf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] i_sel,
  input wire logic [2:0] j_sel,
  input wire logic [2:0] k_sel,
  input wire logic [`IBF_PADDR_W-1:0] ai_val,
  input wire logic [`IBF_WORD_W-1:0] si_val,
  input wire ibf_mreq_t mem_req,
  input wire ibf_issue_t issue,
  input wire logic out_of_buffer,
  input wire logic [`IBF_PARCEL_W-1:0] next_parcel_reg,
  input wire logic [`IBF_PARCEL_W-1:0] current_parcel_reg,
  input wire logic [`IBF_PADDR_W-1:0] ai_op,
  input wire logic [`IBF_PADDR_W-1:0] aj_op,
  input wire logic [`IBF_PADDR_W-1:0] ak_op,
  input wire logic [`IBF_WORD_W-1:0] si_op,
  input wire logic [`IBF_WORD_W-1:0] sj_op,
  input wire logic [`IBF_WORD_W-1:0] sk_op
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_miss_pulse: assert property (out_of_buffer |=> !out_of_buffer)
    else $error("miss flag held too long");
  chk_refill_start: assert property (out_of_buffer |=>
    (mem_req.valid && mem_req.addr[3:0] == 4'h0) ##1 mem_req.valid[*8])
    else $error("refill burst missing or not from bank 0");
  chk_refill_step: assert property (mem_req.valid && mem_req.addr[3:0] != 4'h0 |->
    $past(mem_req.valid) && mem_req.addr == $past(mem_req.addr) + 22'h1)
    else $error("refill word out of order");
  chk_stall_fill: assert property (mem_req.valid |-> !issue.valid)
    else $error("issue during refill");
  chk_cur_first: assert property (issue.valid |-> current_parcel_reg == issue.first)
    else $error("current parcel differs from issued parcel");
  chk_second_held: assert property (issue.valid && issue.two_parcel |-> next_parcel_reg == issue.second)
    else $error("second parcel not in next parcel register");
  chk_j_zero: assert property (j_sel == 3'h0 |=> aj_op == `IBF_AJ_ZERO && sj_op == `IBF_SJ_ZERO)
    else $error("j zero constant wrong");
  chk_k_zero: assert property (k_sel == 3'h0 |=> ak_op == `IBF_AK_ZERO && sk_op == `IBF_SK_ZERO)
    else $error("k zero constant wrong");
  chk_i_real: assert property (i_sel == 3'h0 |=> ai_op == $past(ai_val) && si_op == $past(si_val))
    else $error("i zero not taken from register");
endmodule : ibf_fetch_chk
bind ibf_fetch ibf_fetch_chk u_chk (.clk(clk), .rst_b(rst_b), .i_sel(i_sel), .j_sel(j_sel), .k_sel(k_sel),
  .ai_val(ai_val), .si_val(si_val), .mem_req(mem_req), .issue(issue), .out_of_buffer(out_of_buffer),
  .next_parcel_reg(next_parcel_reg), .current_parcel_reg(current_parcel_reg), .ai_op(ai_op), .aj_op(aj_op),
  .ak_op(ak_op), .si_op(si_op), .sj_op(sj_op), .sk_op(sk_op));

// >>> ibf_mem_model.sv
// Purpose: banked memory answering refill words
// Assumes: words returned in request order
// Notes: parcel value is low 16 bits of its parcel address
`timescale 1ns/1ps
`include "ibf_regs.svh"
module ibf_mem_model
  import ibf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire ibf_mreq_t mem_req,
  output ibf_mrsp_t mem_rsp
);
  logic [`IBF_WADDR_W-1:0] q[$];
  logic [`IBF_WADDR_W-1:0] w;
  logic tgl;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q.delete();
      mem_rsp <= '0;
      tgl <= 1'b0;
    end else begin
      tgl <= ~tgl;
      if (mem_req.valid) q.push_back(mem_req.addr);
      if (q.size() > 0 && (!slow || tgl)) begin
        w = q.pop_front();
        mem_rsp.valid <= 1'b1;
        mem_rsp.data <= {w[13:0], 2'h0, w[13:0], 2'h1, w[13:0], 2'h2, w[13:0], 2'h3};
      end else begin
        // idle data toggles so a stale word is never mistaken for a fresh one
        mem_rsp.valid <= 1'b0;
        mem_rsp.data <= ~mem_rsp.data;
      end
    end
  end
endmodule : ibf_mem_model

// >>> tb_top.sv
// Purpose: self-checking bench for ibf_fetch
// Assumes: decode marks two-parcel from parcel address
// Notes: issues past each expected run are ignored
`timescale 1ns/1ps
`include "ibf_regs.svh"
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb_top
  import ibf_pkg::*;
;
  logic clk = 0, rst_b = 0, branch = 0, issue_ready = 0, go = 0, slow = 0;
  logic [23:0] branch_addr = '0, ai_val = '0, aj_val = '0, ak_val = '0, p_hold, p_now;
  logic [63:0] si_val = '0, sj_val = '0, sk_val = '0;
  logic [2:0] i_sel = '0, j_sel = '0, k_sel = '0;
  logic [31:0] rnd = 32'h3c1af5d7;
  logic two_parcel_op;
  ibf_mreq_t mem_req;
  ibf_mrsp_t mem_rsp;
  ibf_issue_t issue;
  logic out_of_buffer;
  logic [15:0] npr, cpr;
  ibf_issue_t exq[$];
  int n_mismatch = 0, n_checks = 0, n_oob = 0, exp_oob = 0;
  always #2 clk = ~clk;
  ibf_fetch DUT (.clk(clk), .rst_b(rst_b), .branch(branch), .branch_addr(branch_addr), .issue_ready(issue_ready),
    .two_parcel_op(two_parcel_op), .mem_rsp(mem_rsp), .i_sel(i_sel), .j_sel(j_sel), .k_sel(k_sel), .ai_val(ai_val),
    .aj_val(aj_val), .ak_val(ak_val), .si_val(si_val), .sj_val(sj_val), .sk_val(sk_val), .mem_req(mem_req),
    .issue(issue), .out_of_buffer(out_of_buffer), .next_parcel_reg(npr), .current_parcel_reg(cpr), .ai_op(),
    .aj_op(), .ak_op(), .si_op(), .sj_op(), .sk_op());
  ibf_mem_model u_mem (.clk(clk), .rst_b(rst_b), .slow(slow), .mem_req(mem_req), .mem_rsp(mem_rsp));
  // offset 63 stays single so no instruction straddles a buffer end
  function automatic logic tp(input logic [23:0] p);
    return p[1:0] == 2'h3 && p[5:2] != 4'hf;
  endfunction : tp
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  assign p_now = issue.valid ? issue.addr + (issue.two_parcel ? 24'h2 : 24'h1) : p_hold;
  assign two_parcel_op = tp(p_now);
  always @(posedge clk) begin
    p_hold <= !rst_b ? 24'h0 : branch ? branch_addr : p_now;
    rnd = xs(rnd);
    {i_sel, j_sel, k_sel} <= rnd[8:0];
    ai_val <= rnd[31:8];
    aj_val <= ~rnd[23:0];
    ak_val <= rnd[27:4];
    si_val <= {rnd, ~rnd};
    sj_val <= {~rnd, rnd};
    sk_val <= {rnd, rnd};
    issue_ready <= go && rnd[10:9] != 2'h0;
  end
  always @(posedge clk) begin
    ibf_issue_t e;
    if (rst_b && out_of_buffer === 1'b1) n_oob++;
    if (rst_b && issue.valid === 1'b1 && exq.size() > 0) begin
      e = exq.pop_front();
      `CHK("addr", e.addr, issue.addr)
      `CHK("first", e.first, cpr)
      `CHK("len", e.two_parcel, issue.two_parcel)
      if (e.two_parcel) `CHK("second", e.second, npr)
    end
  end
  task automatic run(input logic br, input logic [23:0] a, input logic ms, input logic sl);
    logic [23:0] pa;
    ibf_issue_t e;
    int k;
    pa = a;
    slow <= sl;
    for (k = 0; k < 12; k++) begin
      e = '{1'b1, tp(pa), pa[15:0], pa[15:0] + 16'h1, pa};
      exq.push_back(e);
      pa = pa + (e.two_parcel ? 24'h2 : 24'h1);
    end
    exp_oob += ms;
    if (br) begin
      branch <= 1'b1;
      branch_addr <= a;
      @(posedge clk);
      branch <= 1'b0;
    end
    go <= 1'b1;
    for (k = 0; k < 800 && exq.size() > 0; k++) @(posedge clk);
    go <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK("left", 0, exq.size())
    `CHK("misses", exp_oob, n_oob)
  endtask : run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // nine runs of at most about 820 cycles each
  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  // five buffers' worth of tags: round-robin evicts tag 0 but keeps 0x100
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    run(1'b0, 24'h000000, 1'b1, 1'b0);
    run(1'b1, 24'h000100, 1'b1, 1'b1);
    run(1'b1, 24'h000010, 1'b0, 1'b0);
    run(1'b1, 24'h000200, 1'b1, 1'b0);
    run(1'b1, 24'h000300, 1'b1, 1'b1);
    run(1'b1, 24'h000400, 1'b1, 1'b0);
    run(1'b1, 24'h000120, 1'b0, 1'b1);
    run(1'b1, 24'h000008, 1'b1, 1'b0);
    run(1'b1, 24'hffffc0, 1'b1, 1'b1);
    end_sim();
  end
endmodule : tb_top
